/* dpmgc_pkg.sv */
// dscp priority map and global control: shared offsets, field layout, reset values
// assumes a 32-bit AXI4-Lite master, one register per aligned word at four times the index
package dpmgc_pkg;

	// register indices; byte address is four times the index
	localparam logic [9:0] IDX_MAP12 = 10'h09C;
	localparam logic [9:0] IDX_MAP13 = 10'h09D;
	localparam logic [9:0] IDX_MAP14 = 10'h09E;
	localparam logic [9:0] IDX_MAP15 = 10'h09F;
	localparam logic [9:0] IDX_DRIVE = 10'h0A3;
	localparam logic [9:0] IDX_SNOOP = 10'h0A4;

	localparam int ADDR_W = 12;

	// map fields
	localparam logic [7:0] MAP_RST = 8'h00;
	localparam logic [5:0] DSCP_FIRST = 6'h30;
	localparam logic [1:0] DSCP_UPPER_TAG = 2'h3;

	// drive strength register
	localparam int IF_DRIVE_LSB = 4;
	localparam int GPIO_DRIVE_LSB = 0;
	localparam logic [2:0] IF_DRIVE_RST = 3'h6;
	localparam logic [2:0] GPIO_DRIVE_RST = 3'h2;
	localparam logic [2:0] DRIVE_CODE_RSVD = 3'h0;
	localparam logic [7:0] DRIVE_FIXED = 8'h00;

	// snooping register
	localparam int MLD_OPTION_BIT = 3;
	localparam int MLD_ENABLE_BIT = 2;
	localparam logic MLD_OPTION_RST = 1'b0;
	localparam logic MLD_ENABLE_RST = 1'b0;
	localparam logic [3:0] SNOOP_FIXED_HI = 4'h2;
	localparam logic [1:0] SNOOP_FIXED_LO = 2'h2;

	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		SEL_NONE = 3'b000,
		SEL_MAP12 = 3'b001,
		SEL_MAP13 = 3'b010,
		SEL_MAP14 = 3'b011,
		SEL_MAP15 = 3'b100,
		SEL_DRIVE = 3'b101,
		SEL_SNOOP = 3'b110
	} dpmgc_sel_type;

endpackage

/* dpmgc_wr_capture.sv */
// dscp priority map and global control: AXI4-Lite write address and data capture
// assumes AXI4-Lite handshakes; the register file acknowledges a held pair with wrAck
`timescale 1ns/1ps
module dpmgc_wr_capture (
	input wire logic clk,
	input wire logic srst,
	input wire logic awValid,
	output logic awReady,
	input wire logic [dpmgc_pkg::ADDR_W-1:0] awAddr,
	input wire logic wValid,
	output logic wReady,
	input wire logic [31:0] wData,
	input wire logic [3:0] wStrb,
	output logic wrReq,
	output logic [dpmgc_pkg::ADDR_W-1:0] wrAddr,
	output logic [31:0] wrData,
	output logic [3:0] wrStrb,
	input wire logic wrAck
);

	typedef struct packed {
		logic awHeld;
		logic wHeld;
		logic [dpmgc_pkg::ADDR_W-1:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} dpmgc_cap_type;

	dpmgc_cap_type st_ff;
	dpmgc_cap_type nxt_st;

	assign awReady = ~st_ff.awHeld;
	assign wReady = ~st_ff.wHeld;
	assign wrReq = st_ff.awHeld & st_ff.wHeld;
	assign wrAddr = st_ff.addr;
	assign wrData = st_ff.data;
	assign wrStrb = st_ff.strb;

	// address and data may arrive in either order; the pair is released together
	always_comb begin
		nxt_st = st_ff;
		if (wrAck) begin
			nxt_st.awHeld = 1'b0;
			nxt_st.wHeld = 1'b0;
		end
		if (awValid && !st_ff.awHeld) begin
			nxt_st.awHeld = 1'b1;
			nxt_st.addr = awAddr;
		end
		if (wValid && !st_ff.wHeld) begin
			nxt_st.wHeld = 1'b1;
			nxt_st.data = wData;
			nxt_st.strb = wStrb;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

endmodule

/* dpmgc_prio_lookup.sv */
// dscp priority map and global control: lookup of a dscp code in the upper map entries
// assumes dscpValid and dscpCode come from logic on clk; answer follows one edge later
`timescale 1ns/1ps
module dpmgc_prio_lookup (
	input wire logic clk,
	input wire logic srst,
	input wire logic dscpValid,
	input wire logic [5:0] dscpCode,
	input wire logic [31:0] mapTable,
	output logic prioValid,
	output logic prioHit,
	output logic [1:0] prioLevel
);

	typedef struct packed {
		logic valid;
		logic hit;
		logic [1:0] level;
	} dpmgc_look_type;

	dpmgc_look_type st_ff;
	dpmgc_look_type nxt_st;

	// two-bit field of entry idx, lowest code in the lowest pair
	function automatic logic [1:0] entrySel(input logic [31:0] tbl, input logic [3:0] idx);
		logic [4:0] pos;
		pos = {idx, 1'b0};
		entrySel = tbl[pos +: 2];
	endfunction

	assign prioValid = st_ff.valid;
	assign prioHit = st_ff.hit;
	assign prioLevel = st_ff.level;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.valid = dscpValid;
		if (dscpValid) begin
			// codes below the first upper entry are held elsewhere and report no hit
			nxt_st.hit = (dscpCode[5:4] == dpmgc_pkg::DSCP_UPPER_TAG);
			if (dscpCode[5:4] == dpmgc_pkg::DSCP_UPPER_TAG) begin
				nxt_st.level = entrySel(mapTable, dscpCode[3:0]);
			end else begin
				nxt_st.level = 2'h0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

endmodule

/* dpmgc_top.sv */
// dscp priority map and global control: AXI4-Lite register bank and dscp lookup
// assumes one AXI4-Lite master on clk (10 MHz), synchronous active-high srst,
// and dscp lookup requests from logic on the same clock;
// software writes reserved bits back as read, and only byte lane 0 is stored
//
// Function
// - each upper dscp code selects its own two-bit priority field in the map
// - map 15 holds codes 0x3C..0x3F, 0x3C in bits 1-0, 0x3F in 7-6
// - map 13 holds codes 0x34..0x37, lowest code in the lowest bit pair
// - map 14 holds codes 0x38..0x3B, lowest code in the lowest bit pair
// - every map field resets to 00, lowest priority
// - general output drive code, bits 2-0, resets 010; 000 is reserved
// - bit 2 of the snooping register enables MLD snooping, resets 0
// - separate snooping bit enables the extra MLD option, resets 0
`timescale 1ns/1ps
module dpmgc_top (
	input wire logic clk,
	input wire logic srst,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [dpmgc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [dpmgc_pkg::ADDR_W-1:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire logic dscpValid,
	input wire logic [5:0] dscpCode,
	output logic prioValid,
	output logic prioHit,
	output logic [1:0] prioLevel,
	output logic [2:0] ifDriveCode,
	output logic [2:0] gpioDriveCode,
	output logic mldSnoopEnable,
	output logic mldSnoopOption
);

	typedef struct packed {
		logic [7:0] map12;
		logic [7:0] map13;
		logic [7:0] map14;
		logic [7:0] map15;
		logic [2:0] ifDrive;
		logic [2:0] gpioDrive;
		logic mldEnable;
		logic mldOption;
		logic bValid;
		logic [1:0] bResp;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
	} dpmgc_regs_type;

	dpmgc_regs_type st_ff;
	dpmgc_regs_type nxt_st;

	logic wrReq;
	logic wrAck;
	logic [dpmgc_pkg::ADDR_W-1:0] wrAddr;
	logic [31:0] wrData;
	logic [3:0] wrStrb;
	logic [31:0] mapTable;

	// word index decode shared by the read and write paths
	function automatic dpmgc_pkg::dpmgc_sel_type regSel(
		input logic [dpmgc_pkg::ADDR_W-1:0] addr
	);
		logic [9:0] idx;
		idx = addr[dpmgc_pkg::ADDR_W-1:2];
		case (idx)
			dpmgc_pkg::IDX_MAP12: begin
				regSel = dpmgc_pkg::SEL_MAP12;
			end
			dpmgc_pkg::IDX_MAP13: begin
				regSel = dpmgc_pkg::SEL_MAP13;
			end
			dpmgc_pkg::IDX_MAP14: begin
				regSel = dpmgc_pkg::SEL_MAP14;
			end
			dpmgc_pkg::IDX_MAP15: begin
				regSel = dpmgc_pkg::SEL_MAP15;
			end
			dpmgc_pkg::IDX_DRIVE: begin
				regSel = dpmgc_pkg::SEL_DRIVE;
			end
			dpmgc_pkg::IDX_SNOOP: begin
				regSel = dpmgc_pkg::SEL_SNOOP;
			end
			default: begin
				regSel = dpmgc_pkg::SEL_NONE;
			end
		endcase
	endfunction

	// answer code for a decoded access
	function automatic logic [1:0] respFor(input dpmgc_pkg::dpmgc_sel_type sel);
		if (sel == dpmgc_pkg::SEL_NONE) begin
			respFor = dpmgc_pkg::RESP_SLVERR;
		end else begin
			respFor = dpmgc_pkg::RESP_OKAY;
		end
	endfunction

	// read view of one register, reserved bits at their fixed values
	function automatic logic [7:0] readByte(
		input dpmgc_pkg::dpmgc_sel_type sel,
		input dpmgc_regs_type r
	);
		case (sel)
			dpmgc_pkg::SEL_MAP12: begin
				readByte = r.map12;
			end
			dpmgc_pkg::SEL_MAP13: begin
				readByte = r.map13;
			end
			dpmgc_pkg::SEL_MAP14: begin
				readByte = r.map14;
			end
			dpmgc_pkg::SEL_MAP15: begin
				readByte = r.map15;
			end
			dpmgc_pkg::SEL_DRIVE: begin
				readByte = dpmgc_pkg::DRIVE_FIXED;
				readByte[dpmgc_pkg::IF_DRIVE_LSB +: 3] = r.ifDrive;
				readByte[dpmgc_pkg::GPIO_DRIVE_LSB +: 3] = r.gpioDrive;
			end
			dpmgc_pkg::SEL_SNOOP: begin
				readByte = {dpmgc_pkg::SNOOP_FIXED_HI, 2'h0, dpmgc_pkg::SNOOP_FIXED_LO};
				readByte[dpmgc_pkg::MLD_OPTION_BIT] = r.mldOption;
				readByte[dpmgc_pkg::MLD_ENABLE_BIT] = r.mldEnable;
			end
			default: begin
				readByte = 8'h00;
			end
		endcase
	endfunction

	// the reserved code would leave the pins undefined; writing it to the general output field keeps the old code
	function automatic logic [2:0] driveKeep(
		input logic [2:0] oldCode,
		input logic [2:0] newCode
	);
		if (newCode == dpmgc_pkg::DRIVE_CODE_RSVD) begin
			driveKeep = oldCode;
		end else begin
			driveKeep = newCode;
		end
	endfunction

	// register contents after a byte lane 0 write to the decoded register
	function automatic dpmgc_regs_type writeReg(
		input dpmgc_pkg::dpmgc_sel_type sel,
		input logic [7:0] wb,
		input dpmgc_regs_type r
	);
		dpmgc_regs_type n;
		n = r;
		case (sel)
			dpmgc_pkg::SEL_MAP12: begin
				n.map12 = wb;
			end
			dpmgc_pkg::SEL_MAP13: begin
				n.map13 = wb;
			end
			dpmgc_pkg::SEL_MAP14: begin
				n.map14 = wb;
			end
			dpmgc_pkg::SEL_MAP15: begin
				n.map15 = wb;
			end
			dpmgc_pkg::SEL_DRIVE: begin
				// bits 7 and 3 are fixed and not stored
				n.ifDrive = wb[dpmgc_pkg::IF_DRIVE_LSB +: 3];
				n.gpioDrive = driveKeep(r.gpioDrive, wb[dpmgc_pkg::GPIO_DRIVE_LSB +: 3]);
			end
			dpmgc_pkg::SEL_SNOOP: begin
				n.mldEnable = wb[dpmgc_pkg::MLD_ENABLE_BIT];
				n.mldOption = wb[dpmgc_pkg::MLD_OPTION_BIT];
			end
			default: begin
				n.bResp = dpmgc_pkg::RESP_SLVERR;
			end
		endcase
		writeReg = n;
	endfunction

	// contents after reset: maps cleared, drive codes at their defaults, snooping off
	function automatic dpmgc_regs_type resetState();
		dpmgc_regs_type n;
		n = '0;
		n.map12 = dpmgc_pkg::MAP_RST;
		n.map13 = dpmgc_pkg::MAP_RST;
		n.map14 = dpmgc_pkg::MAP_RST;
		n.map15 = dpmgc_pkg::MAP_RST;
		n.ifDrive = dpmgc_pkg::IF_DRIVE_RST;
		n.gpioDrive = dpmgc_pkg::GPIO_DRIVE_RST;
		n.mldEnable = dpmgc_pkg::MLD_ENABLE_RST;
		n.mldOption = dpmgc_pkg::MLD_OPTION_RST;
		n.bValid = 1'b0;
		n.bResp = dpmgc_pkg::RESP_OKAY;
		n.rValid = 1'b0;
		n.rData = 32'h00000000;
		n.rResp = dpmgc_pkg::RESP_OKAY;
		resetState = n;
	endfunction

	dpmgc_wr_capture u_wr_capture (
		.clk(clk),
		.srst(srst),
		.awValid(s_axi_awvalid),
		.awReady(s_axi_awready),
		.awAddr(s_axi_awaddr),
		.wValid(s_axi_wvalid),
		.wReady(s_axi_wready),
		.wData(s_axi_wdata),
		.wStrb(s_axi_wstrb),
		.wrReq(wrReq),
		.wrAddr(wrAddr),
		.wrData(wrData),
		.wrStrb(wrStrb),
		.wrAck(wrAck)
	);

	// entry i of the upper map sits at bits 2i+1..2i
	assign mapTable = {st_ff.map15, st_ff.map14, st_ff.map13, st_ff.map12};

	dpmgc_prio_lookup u_prio_lookup (
		.clk(clk),
		.srst(srst),
		.dscpValid(dscpValid),
		.dscpCode(dscpCode),
		.mapTable(mapTable),
		.prioValid(prioValid),
		.prioHit(prioHit),
		.prioLevel(prioLevel)
	);

	// a held write is taken only once the previous response has gone
	assign wrAck = wrReq & ~st_ff.bValid;
	// one read at a time keeps rdata standing until it is taken
	assign s_axi_arready = ~st_ff.rValid;

	assign s_axi_bvalid = st_ff.bValid;
	assign s_axi_bresp = st_ff.bResp;
	assign s_axi_rvalid = st_ff.rValid;
	assign s_axi_rdata = st_ff.rData;
	assign s_axi_rresp = st_ff.rResp;
	assign ifDriveCode = st_ff.ifDrive;
	assign gpioDriveCode = st_ff.gpioDrive;
	assign mldSnoopEnable = st_ff.mldEnable;
	assign mldSnoopOption = st_ff.mldOption;

	always_comb begin
		dpmgc_pkg::dpmgc_sel_type rdSel;
		dpmgc_pkg::dpmgc_sel_type wrSel;
		logic [7:0] wrByte;
		rdSel = regSel(s_axi_araddr);
		wrSel = regSel(wrAddr);
		wrByte = wrData[7:0];
		nxt_st = st_ff;

		// read channel: one outstanding read, answered the edge after it is taken
		if (st_ff.rValid && s_axi_rready) begin
			nxt_st.rValid = 1'b0;
		end
		if (s_axi_arvalid && !st_ff.rValid) begin
			nxt_st.rValid = 1'b1;
			nxt_st.rData = {24'h000000, readByte(rdSel, st_ff)};
			nxt_st.rResp = respFor(rdSel);
		end

		// write response
		if (st_ff.bValid && s_axi_bready) begin
			nxt_st.bValid = 1'b0;
		end
		if (wrAck) begin
			nxt_st.bValid = 1'b1;
			nxt_st.bResp = respFor(wrSel);
		end

		// register update; only byte lane 0 carries register bits
		if (wrAck && wrStrb[0]) begin
			nxt_st = writeReg(wrSel, wrByte, nxt_st);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_ff <= resetState();
		end else begin
			st_ff <= nxt_st;
		end
	end

endmodule

/* dpmgc_top_monitor.sv */
// checker for the dscp map bank, watching dpmgc_top ports only
// assumes one clock and synchronous active-high srst
`timescale 1ns/1ps
module dpmgc_monitor (
	input wire logic clk,
	input wire logic srst,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic dscpValid,
	input wire logic [5:0] dscpCode,
	input wire logic prioValid,
	input wire logic prioHit,
	input wire logic [1:0] prioLevel,
	input wire logic [2:0] gpioDriveCode,
	input wire logic mldSnoopEnable
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	property p_lat; dscpValid |=> prioValid; endproperty
	a_lat: assert property (p_lat) else $error("lookup answer late");
	property p_pulse; !dscpValid |=> !prioValid; endproperty
	a_pulse: assert property (p_pulse) else $error("lookup answer unasked");
	property p_miss; dscpValid && dscpCode < 6'h30 |=> !prioHit && prioLevel == 2'h0; endproperty
	a_miss: assert property (p_miss) else $error("low code hit");
	property p_hit; dscpValid && dscpCode >= 6'h30 |=> prioHit; endproperty
	a_hit: assert property (p_hit) else $error("upper code missed");
	property p_gpio; gpioDriveCode != 3'h0; endproperty
	a_gpio: assert property (p_gpio) else $error("reserved drive code");
	property p_gchg; !$past(srst) && $changed(gpioDriveCode) |-> $rose(s_axi_bvalid); endproperty
	a_gchg: assert property (p_gchg) else $error("drive code moved alone");
	property p_mchg; !$past(srst) && $changed(mldSnoopEnable) |-> $rose(s_axi_bvalid); endproperty
	a_mchg: assert property (p_mchg) else $error("mld enable moved alone");
	property p_rhi; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
	a_rhi: assert property (p_rhi) else $error("upper read bits set");
	property p_rlat; s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid; endproperty
	a_rlat: assert property (p_rlat) else $error("read answer late");
	property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped");
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_bhold: assert property (p_bhold) else $error("write answer dropped");
endmodule
bind dpmgc_top dpmgc_monitor u_mon (.clk(clk), .srst(srst), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.dscpValid(dscpValid), .dscpCode(dscpCode), .prioValid(prioValid), .prioHit(prioHit),
	.prioLevel(prioLevel), .gpioDriveCode(gpioDriveCode), .mldSnoopEnable(mldSnoopEnable));

/* test_dscp_priority_map_and_global_ctrl.sv */
// self-checking bench for dpmgc_top: AXI4-Lite register access and dscp lookups
// assumes the 10 MHz clock and synchronous reset made here
`timescale 1ns/1ps
module test_dscp_priority_map_and_global_ctrl;
	logic clk = 0, srst = 1, awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
	logic dscpValid = 0, awReady, wReady, bValid, arReady, rValid, prioValid, prioHit;
	logic mldEn, mldOpt;
	logic [11:0] awAddr = 0, arAddr = 0;
	logic [31:0] wData = 0, rData;
	logic [1:0] bResp, rResp, prioLevel;
	logic [5:0] dscpCode = 0;
	logic [3:0] wStrb = 4'hF;
	logic [2:0] ifDrv, gpioDrv;
	logic [7:0] mp [4] = '{8'hC6, 8'hE4, 8'h1B, 8'h39};
	int error_cnt = 0, tests_run = 0;
	always #50 clk = ~clk;
	dpmgc_top DUT (.clk(clk), .srst(srst), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_awaddr(awAddr), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
		.s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_bresp(bResp), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_araddr(arAddr), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .dscpValid(dscpValid), .dscpCode(dscpCode),
		.prioValid(prioValid), .prioHit(prioHit), .prioLevel(prioLevel), .ifDriveCode(ifDrv),
		.gpioDriveCode(gpioDrv), .mldSnoopEnable(mldEn), .mldSnoopOption(mldOpt));
	task automatic chk(input bit ok, input string m);
		tests_run++;
		if (!ok) begin
			error_cnt++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task automatic finish_test();
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// bready raised late so the response must stand
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e);
		int n = 0;
		awAddr <= a;
		wData <= {24'h0, d};
		awValid <= 1'h1;
		wValid <= 1'h1;
		forever begin
			@(posedge clk);
			if (bValid === 1'h1 && bReady === 1'h1) break;
			if (awReady === 1'h1) awValid <= 1'h0;
			if (wReady === 1'h1) wValid <= 1'h0;
			n++;
			bReady <= n > 2;
		end
		bReady <= 1'h0;
		chk(bResp === e, "write response");
		@(posedge clk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e);
		int n = 0;
		arAddr <= a;
		arValid <= 1'h1;
		forever begin
			@(posedge clk);
			if (rValid === 1'h1 && rReady === 1'h1) break;
			if (arReady === 1'h1) arValid <= 1'h0;
			n++;
			rReady <= n > 1;
		end
		rReady <= 1'h0;
		chk(rData === {24'h0, d} && rResp === e, "read data");
		@(posedge clk);
	endtask
	task automatic lk(input logic [5:0] c, input logic h, input logic [1:0] l);
		dscpValid <= 1'h1;
		dscpCode <= c;
		@(posedge clk);
		dscpValid <= 1'h0;
		@(posedge clk);
		chk(prioValid === 1'h1 && prioHit === h && prioLevel === l, "lookup");
	endtask
	initial begin
		#500000;
		error_cnt++;
		finish_test();
	end
	initial begin
		repeat (10) @(posedge clk);
		srst <= 1'h0;
		@(posedge clk);
		for (int i = 0; i < 4; i++) rd(12'h270 + 12'(4 * i), 8'h00, 2'h0);
		rd(12'h28C, 8'h62, 2'h0);
		rd(12'h290, 8'h22, 2'h0);
		chk(gpioDrv === 3'h2 && ifDrv === 3'h6 && mldEn === 1'h0 && mldOpt === 1'h0, "reset");
		lk(6'h3F, 1'h1, 2'h0);
		for (int i = 0; i < 4; i++) wr(12'h270 + 12'(4 * i), mp[i], 2'h0);
		for (int i = 0; i < 4; i++) rd(12'h270 + 12'(4 * i), mp[i], 2'h0);
		for (int c = 0; c < 16; c++) lk(6'h30 + 6'(c), 1'h1, 2'(mp[c / 4] >> (2 * (c % 4))));
		lk(6'h2F, 1'h0, 2'h0);
		// both drive fields set to the same code, reserved bits written as ones
		for (int c = 1; c < 8; c++) begin
			wr(12'h28C, 8'(c * 17) | 8'h88, 2'h0);
			rd(12'h28C, 8'(c * 17), 2'h0);
			chk(gpioDrv === 3'(c) && ifDrv === 3'(c), "drive code");
		end
		wr(12'h28C, 8'h70, 2'h0);
		chk(gpioDrv === 3'h7, "reserved drive code");
		wr(12'h28C, 8'h52, 2'h0);
		chk(ifDrv === 3'h5 && gpioDrv === 3'h2, "gigabit drive");
		wr(12'h290, 8'h04, 2'h0);
		chk(mldEn === 1'h1 && mldOpt === 1'h0, "mld enable");
		wr(12'h290, 8'hFF, 2'h0);
		rd(12'h290, 8'h2E, 2'h0);
		wStrb <= 4'hE;
		wr(12'h290, 8'h00, 2'h0);
		wStrb <= 4'hF;
		chk(mldEn === 1'h1, "masked write");
		chk(mldOpt === 1'h1, "mld option");
		wr(12'h300, 8'h55, 2'h2);
		rd(12'h300, 8'h00, 2'h2);
		srst <= 1'h1;
		repeat (3) @(posedge clk);
		srst <= 1'h0;
		@(posedge clk);
		rd(12'h27C, 8'h00, 2'h0);
		lk(6'h3C, 1'h1, 2'h0);
		rd(12'h28C, 8'h62, 2'h0);
		chk(mldEn === 1'h0 && mldOpt === 1'h0, "snoop after reset");
		finish_test();
	end
endmodule
